//--- adc_pkg.sv
package adc_pkg;

   localparam int RES_W = 12;
   localparam int HALF_W = 8;
   localparam int ZF_W = 4;
   localparam int CNT_W = 9;

   localparam int CLK_PERIOD_NS = 25;
   // longest conversion time, rounded down to whole cycles
   localparam int CONV_TIME_NS = 8000;
   localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
   // full acquire and convert cycle, informative for the controller
   localparam int CYCLE_TIME_NS = 10000;
   localparam int CYCLE_CYCLES = CYCLE_TIME_NS / CLK_PERIOD_NS;

   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_RST = 9'h000;
   localparam logic [RES_W-1:0] RES_RST = 12'h000;
   localparam logic [ZF_W-1:0] ZF_LEVEL = 4'h0;

   typedef enum logic {
      ST_TRACK,
      ST_CONVERT
   } conv_state_t;

endpackage : adc_pkg

//--- adc_read_port.sv
// Function
// RQ1: result pins float unless select is low and read/convert is high.
// RQ2: highest result pin carries the msb, lowest pin the lsb.
// RQ3: each result is a 12-bit two's complement parallel word.
// RQ4: zero-fill pins drive low while read is enabled, float otherwise.
// RQ5: half select low gives upper 8 bits, high gives lower 8 bits.
// RQ6: convert starts when select and read/convert are low and not busy.
// RQ7: read/convert rising with select low enables the result pins.
// RQ8: select and read/convert are OR'd; either falling may start conversion.
// RQ9: busy goes low at start, high after the result register updates.
// RQ10: conversion ends within 8 us; full cycle within 10 us.
// RQ11: convert commands are ignored while busy is low.
// RQ12: controller holds the convert request low 40 ns to 6 us.
// RQ13: controller releases the request before busy rises, else reconverts.
// RQ14: controller reads after busy rises, both halves via half select.
// RQ15: after reset busy is high and result pins float.
`timescale 1ns/1ps

module adc_read_port
   import adc_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic select_n,
   input wire logic read_conv,
   input wire logic half_sel,
   input wire logic [RES_W-1:0] sample_code,
   output logic [RES_W-1:0] result_o,
   output logic result_oe,
   output logic [ZF_W-1:0] zero_fill_outputs,
   output logic zero_fill_oe,
   output logic busy_n,
   output logic hold
);

   ////////////////////////////////////////////////////////////////////////
   // command decode

   logic read_en;
   logic start;
   logic conv_req;

   // low on both inputs asserts the combined command
   assign conv_req = ~(select_n | read_conv); // RQ8
   assign read_en = ~select_n & read_conv; // RQ1 RQ7

   ////////////////////////////////////////////////////////////////////////
   // conversion sequencer

   conv_state_t state_q;
   conv_state_t state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic busy_n_q;
   logic busy_n_d;
   logic hold_q;
   logic hold_d;
   logic [RES_W-1:0] result_q;
   logic [RES_W-1:0] result_d;

   // level sensitive: a request still low when busy rises restarts at once
   assign start = conv_req & (state_q == ST_TRACK); // RQ6 RQ11 RQ13

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      busy_n_d = busy_n_q;
      hold_d = hold_q;
      result_d = result_q;
      unique case (state_q)
         ST_TRACK: begin
            if (start) begin
               state_d = ST_CONVERT; // RQ6
               cnt_d = CNT_RST;
               busy_n_d = 1'b0; // RQ9
               hold_d = 1'b1;
            end
         end
         ST_CONVERT: begin
            // new requests are not looked at here
            if (cnt_q == CNT_LAST) begin // RQ10 RQ11
               state_d = ST_TRACK;
               result_d = sample_code; // RQ3
               busy_n_d = 1'b1; // RQ9
               hold_d = 1'b0;
            end else begin
               cnt_d = cnt_q + 9'h001;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state_q <= ST_TRACK;
         cnt_q <= CNT_RST;
         busy_n_q <= 1'b1; // RQ15
         hold_q <= 1'b0;
         result_q <= RES_RST;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         busy_n_q <= busy_n_d;
         hold_q <= hold_d;
         result_q <= result_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output bus

   logic [RES_W-1:0] bus_q;
   logic [RES_W-1:0] bus_d;
   logic oe_q;
   logic oe_d;
   logic [ZF_W-1:0] zf_q;
   logic [ZF_W-1:0] zf_d;

   always_comb begin
      oe_d = read_en; // RQ1 RQ4 RQ7
      zf_d = ZF_LEVEL; // RQ4
      if (!half_sel) begin
         // full word; the top byte pins carry the upper 8 bits
         bus_d = result_q; // RQ2 RQ5
      end else begin
         // lower 8 bits moved onto the top byte pins
         bus_d = {result_q[HALF_W-1:0], result_q[RES_W-1:HALF_W]}; // RQ5
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         bus_q <= RES_RST;
         oe_q <= 1'b0; // RQ15
         zf_q <= ZF_LEVEL;
      end else begin
         bus_q <= bus_d;
         oe_q <= oe_d;
         zf_q <= zf_d;
      end
   end

   assign result_o = bus_q;
   assign result_oe = oe_q;
   assign zero_fill_outputs = zf_q;
   assign zero_fill_oe = oe_q;
   assign busy_n = busy_n_q;
   assign hold = hold_q;

   ////////////////////////////////////////////////////////////////////////
   // checks

   logic [CNT_W:0] low_run_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         low_run_q <= 10'h000;
      end else if (!busy_n_q) begin
         low_run_q <= low_run_q + 10'h001;
      end else begin
         low_run_q <= 10'h000;
      end
   end

   default clocking cb @(posedge clk);
   endclocking

   default disable iff (!resetn);

   read_enable_a: assert property ( // RQ1
      result_oe == $past(~select_n & read_conv))
      else $error("result enable does not follow select and read");

   zero_fill_a: assert property ( // RQ4
      zero_fill_oe |-> (zero_fill_outputs == ZF_LEVEL)
                       && result_oe)
      else $error("zero fill not low with read enabled");

   conv_start_a: assert property ( // RQ6
      (busy_n && !select_n && !read_conv) |=> !busy_n && hold)
      else $error("conversion did not start on request");

   conv_length_a: assert property ( // RQ10
      $rose(busy_n) |-> low_run_q == 10'(CONV_CYCLES))
      else $error("busy low time is not the conversion time");

   conv_bound_a: assert property ( // RQ10
      $fell(busy_n) |-> ##[1:320] busy_n)
      else $error("conversion overran its bound");

   result_update_a: assert property ( // RQ9
      $rose(busy_n) |-> result_q == $past(sample_code))
      else $error("result not updated as busy rises");

   ignore_cmd_a: assert property ( // RQ11
      (!busy_n && $past(!busy_n)) |-> cnt_q == $past(cnt_q) + 9'h001)
      else $error("conversion disturbed while busy");

   upper_half_a: assert property ( // RQ5
      (result_oe && !$past(half_sel)) |-> result_o == $past(result_q))
      else $error("full word not presented msb first");

   lower_half_a: assert property ( // RQ5
      $past(half_sel) |->
         result_o[RES_W-1:ZF_W] == $past(result_q[HALF_W-1:0]))
      else $error("lower half not on the top byte pins");

   reset_state_a: assert property ( // RQ15
      $rose(resetn) |-> busy_n && !result_oe)
      else $error("not idle after reset");

   ////////////////////////////////////////////////////////////////////////
   // checks: read port pins

   read_off_a: assert property ( // RQ1
      (select_n || !read_conv)
      |=> !result_oe)
      else $error("result pins enabled without a read");

   read_on_a: assert property ( // RQ7
      (!select_n && $rose(read_conv))
      |=> result_oe)
      else $error("read rise did not enable the pins");

   oe_pair_a: assert property ( // RQ4
      zero_fill_oe
      == result_oe)
      else $error("zero fill enable differs from result enable");

   zero_idle_a: assert property ( // RQ4
      zero_fill_outputs
      == ZF_LEVEL)
      else $error("zero fill pins not low");

   byte_low_a: assert property ( // RQ5
      (result_oe && $past(half_sel))
      |-> result_o[ZF_W-1:0] == $past(result_q[RES_W-1:HALF_W]))
      else $error("low pins wrong in byte mode");

   ////////////////////////////////////////////////////////////////////////
   // checks: conversion sequencer

   rc_start_a: assert property ( // RQ6
      ($fell(read_conv) && !select_n && busy_n)
      |=> !busy_n && !result_oe)
      else $error("read/convert fall did not start");

   cs_start_a: assert property ( // RQ8
      ($fell(select_n) && !read_conv && busy_n)
      |=> !busy_n)
      else $error("select fall did not start");

   hold_mirror_a: assert property ( // RQ9
      hold
      == !busy_n)
      else $error("hold does not mirror busy");

   busy_fall_a: assert property ( // RQ9
      $fell(busy_n)
      |-> hold && cnt_q == CNT_RST)
      else $error("conversion started with a stale count");

   result_hold_a: assert property ( // RQ9
      $changed(result_q)
      |-> $rose(busy_n))
      else $error("result changed away from the end of conversion");

   track_state_a: assert property ( // RQ9
      busy_n
      |-> state_q == ST_TRACK)
      else $error("busy high while converting");

   busy_steady_a: assert property ( // RQ11
      (!busy_n && cnt_q != CNT_LAST)
      |=> !busy_n)
      else $error("conversion cut short");

   idle_stay_a: assert property ( // RQ11
      (busy_n && (select_n || read_conv))
      |=> busy_n)
      else $error("conversion started without a request");

   run_limit_a: assert property ( // RQ10
      low_run_q
      <= 10'(CONV_CYCLES))
      else $error("busy low longer than the conversion time");

   count_range_a: assert property ( // RQ10
      cnt_q
      <= CNT_LAST)
      else $error("conversion counter out of range");

   restart_a: assert property ( // RQ13
      ($rose(busy_n) && !select_n && !read_conv)
      |=> !busy_n)
      else $error("held request did not restart");

endmodule : adc_read_port

//--- ctl_model.sv
`timescale 1ns/1ps
module ctl_model (
   input wire logic clk,
   output logic select_n,
   output logic read_conv,
   output logic half_sel
);
   initial begin
      select_n = 1'b1;
      read_conv = 1'b1;
      half_sel = 1'b0;
   end
   task automatic drive(input logic cs_n, input logic rc, input logic hs);
      @(negedge clk);
      select_n = cs_n;
      read_conv = rc;
      half_sel = hs;
   endtask : drive
   // request pulse of three cycles, two when started by select, released long before busy returns
   task automatic convert(input logic via_cs);
      drive(via_cs, 1'b0, 1'b0);
      drive(1'b0, 1'b0, 1'b0);
      drive(1'b0, 1'b0, 1'b0);
      drive(1'b1, 1'b1, 1'b0);
   endtask : convert
endmodule : ctl_model

//--- tb.sv
`timescale 1ns/1ps
module tb;
   import adc_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [RES_W-1:0] sample_code = 12'h000;
   logic select_n, read_conv, half_sel, result_oe, zero_fill_oe, busy_n, hold;
   logic [RES_W-1:0] result_o;
   logic [ZF_W-1:0] zero_fill_outputs;
   int mismatches = 0;
   int comparisons = 0;
   always #12.5 clk = ~clk;
   ctl_model ctl_model_inst (.clk(clk), .select_n(select_n),
      .read_conv(read_conv), .half_sel(half_sel));
   adc_read_port adc_read_port_inst (.clk(clk), .resetn(resetn),
      .select_n(select_n), .read_conv(read_conv), .half_sel(half_sel),
      .sample_code(sample_code), .result_o(result_o),
      .result_oe(result_oe), .zero_fill_outputs(zero_fill_outputs),
      .zero_fill_oe(zero_fill_oe), .busy_n(busy_n), .hold(hold));
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string what, input logic [11:0] exp,
         input logic [11:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // second request during the conversion must not stretch it
   task automatic conv(input logic via_cs, input logic extra,
         input logic [11:0] code);
      int n;
      n = 0;
      sample_code = code;
      fork
         begin
            ctl_model_inst.convert(via_cs);
            if (extra) begin
               repeat (20) @(negedge clk);
               ctl_model_inst.convert(1'b0);
            end
         end
         begin
            for (int i = 0; i < 8 && busy_n !== 1'b0; i++) @(negedge clk);
            chk("hold", 12'h001, {11'h000, hold});
            while (busy_n === 1'b0 && n < 400) begin
               n++;
               @(negedge clk);
            end
         end
      join
      chk("busy cycles", 12'(CONV_CYCLES), 12'(n));
      chk("hold done", 12'h000, {11'h000, hold});
   endtask : conv
   task automatic rd(input logic hs, input logic [11:0] exp);
      ctl_model_inst.drive(1'b0, 1'b1, hs);
      @(negedge clk);
      chk("result", exp, result_o);
      chk("enables", 12'h003, {10'h000, result_oe, zero_fill_oe});
      chk("zero fill", 12'h000, {8'h00, zero_fill_outputs});
      ctl_model_inst.drive(1'b1, 1'b1, 1'b0);
      @(negedge clk);
      chk("released", 12'h000, {10'h000, result_oe, zero_fill_oe});
   endtask : rd
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      wrap_up();
   end
   initial begin
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      chk("reset", 12'h001, {9'h000, result_oe, zero_fill_oe, busy_n});
      conv(1'b0, 1'b0, 12'hA53);
      rd(1'b0, 12'hA53);
      rd(1'b1, 12'h53A);
      conv(1'b1, 1'b1, 12'h7FF);
      rd(1'b0, 12'h7FF);
      conv(1'b0, 1'b0, 12'h800);
      rd(1'b1, 12'h008);
      wrap_up();
   end
endmodule : tb
